// ### hdl/rmpc_top.sv
// reset sequencer, mode sampling and port pin control with apb registers
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "rmpc_defines.svh"

// Summary of operation
// - any reset drives reset pin low 4.25us
// - resample reset pin 4.75us after release
// - pin still low at sample means external
// - set matching bit in reset cause register
// - mode pin high at release: run mode
// - mode pin held low: background mode
// - background bit time is 16 clocks
// - pseudo open drain with speedup pulses
// - after reset pins are inputs, no pull
// - direction bit picks data read path
// - owning peripheral drives output buffer enable
// - pull enable acts whenever pin is input
// - keypad rising sensitivity selects pulldowns
// - irq rising edge selects pulldown
// - slew bit selects small slow transistor
// - debug force bit starts a reset
// - range bit selects oscillator range
// - startup runs from internal clock source
// - run mode starts at reset vector
module rmpc_top (
  input wire logic pclk,                         // bus clock, 250 mhz
  input wire logic presetn,                      // power-on reset, active low
  input wire logic psel,                         // apb select
  input wire logic penable,                      // apb access phase
  input wire logic pwrite,                       // apb direction
  input wire logic [11:0] paddr,                 // apb byte address
  input wire logic [31:0] pwdata,                // apb write data
  output logic [31:0] prdata,                    // apb read data
  output logic pready,                           // apb ready
  output logic pslverr,                          // apb error, unmapped
  input wire logic reset_pin_in,                 // reset pin level
  output logic reset_pin_out,                    // reset pin drive value
  output logic reset_pin_oe,                     // reset pin driven low
  input wire logic internal_reset_req,           // pulse from watchdog or low voltage
  input wire logic illegal_op_req,               // pulse from cpu decode
  output logic sys_rst_n,                        // chip reset, active low
  output logic background_mode,                  // 1: active background mode
  output logic [15:0] reset_vector_addr,         // vector fetched in run mode
  input wire logic background_mode_select_pin_in, // mode pin level
  output logic background_mode_select_pin_out,   // mode pin drive value
  output logic background_mode_select_pin_oe,    // mode pin driven
  input wire logic bdc_drive_low,                // debug controller pulls low
  input wire logic bdc_speedup,                  // debug controller speedup pulse
  output logic bdc_bit_tick,                     // start of each bit time
  input wire logic [7:0] port_pin_in,            // port pin levels
  input wire rmpc_pkg::rmpc_periph_t periph,     // peripheral ownership
  output rmpc_pkg::rmpc_pads_t pads,             // pad controls
  input wire logic irq_pin_in,                   // irq pin level
  output logic irq_pull_on,                      // irq pull device enable
  output logic irq_pull_down,                    // irq pull is a pulldown
  output logic osc_range_high,                   // 1: 1-16 mhz, 0: 32-100 khz
  output logic clk_sel_ext                       // 1: external oscillator selected
);
  // ****************************************
  // timing constants
  // ****************************************
  localparam real T_DRIVE_US = `RMPC_T_DRIVE_US;
  localparam real T_SAMPLE_US = `RMPC_T_SAMPLE_US;
  localparam int DRIVE_CYC = int'($ceil(T_DRIVE_US * 1000.0 / `RMPC_CLK_NS));
  localparam int SAMPLE_CYC = int'($ceil(T_SAMPLE_US * 1000.0 / `RMPC_CLK_NS));
  localparam logic [10:0] DRIVE_LAST = 11'(DRIVE_CYC - 1);
  localparam logic [10:0] SAMPLE_LAST = 11'(SAMPLE_CYC - 1);
  localparam logic [3:0] BIT_LAST = 4'(`RMPC_BDC_BIT_CYC - 1);
  localparam int KL = `RMPC_KBI_LO;

  // ****************************************
  // input synchronisers
  // ****************************************
  logic [10:0] sync1_reg;
  logic [10:0] sync2_reg;
  wire logic rst_pin_s = sync2_reg[0];
  wire logic mode_pin_s = sync2_reg[1];
  wire logic irq_s = sync2_reg[2];
  wire logic [7:0] port_s = sync2_reg[10:3];
  // two flops on every pin, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= 11'h7ff;
      sync2_reg <= 11'h7ff;
    end else begin
      sync1_reg <= {port_pin_in, irq_pin_in, background_mode_select_pin_in, reset_pin_in};
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************
  // apb decode
  // ****************************************
  logic ready_reg;
  logic [31:0] rdata_reg;
  logic err_reg;
  logic [7:0] pdata_reg;
  logic [7:0] pdir_reg;
  logic [7:0] ppull_reg;
  logic [7:0] pslew_reg;
  logic [`RMPC_CTRL_W-1:0] ctrl_reg;
  rmpc_pkg::rmpc_cause_t cause_reg;
  rmpc_pkg::rmpc_state_t state_reg;

  // address match; used for both read mux and write strobes
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  wire logic acc = psel & penable;
  wire logic wr_done = acc & ready_reg & pwrite;
  wire logic in_run = (state_reg == rmpc_pkg::ST_RUN);
  wire logic mapped = hit(paddr, `RMPC_OFF_PDATA) | hit(paddr, `RMPC_OFF_PDIR) |
    hit(paddr, `RMPC_OFF_PPULL) | hit(paddr, `RMPC_OFF_PSLEW) | hit(paddr, `RMPC_OFF_CAUSE) |
    hit(paddr, `RMPC_OFF_CTRL) | hit(paddr, `RMPC_OFF_STAT);
  wire logic wr_ok = wr_done & mapped & in_run;
  wire logic force_req = wr_ok & hit(paddr, `RMPC_OFF_CTRL) & pwdata[`RMPC_CTRL_FORCE];
  // read path follows direction, even on peripheral-owned pins
  wire logic [7:0] pdata_rd = (pdir_reg & pdata_reg) | (~pdir_reg & port_s);
  wire logic [31:0] rd_mux =
    hit(paddr, `RMPC_OFF_PDATA) ? {24'h000000, pdata_rd} :
    hit(paddr, `RMPC_OFF_PDIR) ? {24'h000000, pdir_reg} :
    hit(paddr, `RMPC_OFF_PPULL) ? {24'h000000, ppull_reg} :
    hit(paddr, `RMPC_OFF_PSLEW) ? {24'h000000, pslew_reg} :
    hit(paddr, `RMPC_OFF_CAUSE) ? {27'h0000000, cause_reg} :
    hit(paddr, `RMPC_OFF_CTRL) ? {26'h0000000, ctrl_reg & 6'h37} :
    hit(paddr, `RMPC_OFF_STAT) ? {29'h00000000, clk_sel_ext, background_mode, in_run} : 32'h00000000;

  // one wait state so read data comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      err_reg <= 1'b0;
    end else begin
      ready_reg <= acc & ~ready_reg;
      rdata_reg <= (acc & ~ready_reg & ~pwrite) ? rd_mux : 32'h00000000;
      err_reg <= acc & ~ready_reg & ~mapped;
    end
  end
  assign pready = ready_reg;
  assign prdata = rdata_reg;
  assign pslverr = err_reg;

  // ****************************************
  // software registers
  // ****************************************
  // every reset returns pins to unpulled inputs; writes wait for run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pdata_reg <= `RMPC_PORT_RST;
      pdir_reg <= `RMPC_PORT_RST;
      ppull_reg <= `RMPC_PORT_RST;
      pslew_reg <= `RMPC_PORT_RST;
      ctrl_reg <= `RMPC_CTRL_RST;
    end else if (!in_run) begin
      pdata_reg <= `RMPC_PORT_RST;
      pdir_reg <= `RMPC_PORT_RST;
      ppull_reg <= `RMPC_PORT_RST;
      pslew_reg <= `RMPC_PORT_RST;
      ctrl_reg <= `RMPC_CTRL_RST;
    end else if (wr_ok) begin
      if (hit(paddr, `RMPC_OFF_PDATA)) pdata_reg <= pwdata[7:0];
      if (hit(paddr, `RMPC_OFF_PDIR)) pdir_reg <= pwdata[7:0];
      if (hit(paddr, `RMPC_OFF_PPULL)) ppull_reg <= pwdata[7:0];
      if (hit(paddr, `RMPC_OFF_PSLEW)) pslew_reg <= pwdata[7:0];
      if (hit(paddr, `RMPC_OFF_CTRL)) ctrl_reg <= pwdata[`RMPC_CTRL_W-1:0];
    end
  end

  // ****************************************
  // reset sequencer
  // ****************************************
  logic [10:0] cnt_reg;
  rmpc_pkg::rmpc_cause_t pend_reg;
  logic mode_reg;
  wire logic trig_int = internal_reset_req | illegal_op_req | force_req;
  wire logic trig = in_run & (trig_int | ~rst_pin_s);
  wire logic sample_now = (state_reg == rmpc_pkg::ST_WAIT) && (cnt_reg == SAMPLE_LAST);
  // pending cause of a new reset; internal sources rank above a pin pull
  wire rmpc_pkg::rmpc_cause_t trig_cause = '{debug_force: force_req, illegal_op: illegal_op_req,
    internal: internal_reset_req, external: ~trig_int, power_on: 1'b0};
  // a low pin at the sample point overrides any internal cause
  wire rmpc_pkg::rmpc_cause_t decoded = rst_pin_s ? pend_reg :
    '{debug_force: 1'b0, illegal_op: 1'b0, internal: 1'b0, external: 1'b1, power_on: 1'b0};

  // drive, release, resample, then record cause and mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= rmpc_pkg::ST_DRIVE;
      cnt_reg <= 11'h000;
      pend_reg <= '{power_on: 1'b1, default: 1'b0};
      cause_reg <= '0;
      mode_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        rmpc_pkg::ST_DRIVE: begin
          cnt_reg <= (cnt_reg == DRIVE_LAST) ? 11'h000 : cnt_reg + 11'h001;
          if (cnt_reg == DRIVE_LAST) state_reg <= rmpc_pkg::ST_WAIT;
        end
        rmpc_pkg::ST_WAIT: begin
          cnt_reg <= cnt_reg + 11'h001;
          if (sample_now) begin
            cnt_reg <= 11'h000;
            state_reg <= rmpc_pkg::ST_RUN;
            cause_reg <= decoded;
            mode_reg <= ~mode_pin_s;
          end
        end
        rmpc_pkg::ST_RUN: begin
          if (trig) begin
            state_reg <= rmpc_pkg::ST_DRIVE;
            pend_reg <= trig_cause;
          end
        end
      endcase
    end
  end
  assign reset_pin_out = 1'b0;
  assign reset_pin_oe = (state_reg == rmpc_pkg::ST_DRIVE);
  assign sys_rst_n = in_run;
  assign background_mode = mode_reg;
  assign reset_vector_addr = `RMPC_RESET_VECTOR;

  // ****************************************
  // background pin and bit timer
  // ****************************************
  logic [3:0] bit_cnt_reg;
  // free-running bit timer on the bus clock, which is the debug clock here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) bit_cnt_reg <= 4'h0;
    else bit_cnt_reg <= (bit_cnt_reg == BIT_LAST) ? 4'h0 : bit_cnt_reg + 4'h1;
  end
  assign bdc_bit_tick = (bit_cnt_reg == 4'h0);
  // pin only pulled low or briefly pushed high; never driven during reset
  wire logic bdc_en = in_run & (bdc_drive_low | bdc_speedup);
  assign background_mode_select_pin_oe = bdc_en;
  assign background_mode_select_pin_out = bdc_speedup & ~bdc_drive_low;

  // ****************************************
  // port pads
  // ****************************************
  // kbi pins on the upper half; one control bit sets the pull polarity of all owned ones
  genvar gi;
  generate
    for (gi = 0; gi < `RMPC_PORT_W; gi++) begin : g_pad
      wire logic own = periph.own[gi];
      assign pads.oe[gi] = own ? periph.oe[gi] : pdir_reg[gi];
      assign pads.out[gi] = own ? periph.out[gi] : pdata_reg[gi];
      assign pads.pull_on[gi] = ppull_reg[gi] & ~pads.oe[gi];
      assign pads.pull_down[gi] = (gi >= KL) && own && ctrl_reg[`RMPC_CTRL_KBI_RISE];
      assign pads.slow[gi] = pslew_reg[gi];
    end
  endgenerate
  assign irq_pull_on = ctrl_reg[`RMPC_CTRL_IRQ_PULL];
  assign irq_pull_down = ctrl_reg[`RMPC_CTRL_IRQ_RISE];
  assign osc_range_high = ctrl_reg[`RMPC_CTRL_RANGE];
  // self-clocked source through startup, no crystal wait
  assign clk_sel_ext = in_run & ctrl_reg[`RMPC_CTRL_CLK_EXT];

  // ****************************************
  // assertions
  // ****************************************
  logic [11:0] low_len_reg;
  // helper: length of the current low drive on the reset pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) low_len_reg <= 12'h000;
    else low_len_reg <= reset_pin_oe ? low_len_reg + 12'h001 : 12'h000;
  end
  property p_drive_len;
    @(posedge pclk) disable iff (!presetn) $fell(reset_pin_oe) |-> $past(low_len_reg) == 12'd1062;
  endproperty
  a_drive_len: assert property (p_drive_len) else $error("reset pin low time wrong");
  logic [11:0] wait_len_reg;
  // helper: cycles from pin release to the sample point; too long for a delay range
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wait_len_reg <= 12'h000;
    else wait_len_reg <= (!in_run && !reset_pin_oe) ? wait_len_reg + 12'h001 : 12'h000;
  end
  property p_sample_gap;
    @(posedge pclk) disable iff (!presetn) $rose(in_run) |-> wait_len_reg == 12'd1188;
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("resample gap wrong");
  property p_wait_bound;
    @(posedge pclk) disable iff (!presetn) !in_run && !reset_pin_oe |-> wait_len_reg < 12'd1188;
  endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("sample point missed");
  property p_ext_cause;
    @(posedge pclk) disable iff (!presetn) sample_now && !rst_pin_s |=> cause_reg.external;
  endproperty
  a_ext_cause: assert property (p_ext_cause) else $error("external reset not recorded");
  property p_cause_hold;
    @(posedge pclk) disable iff (!presetn) in_run && $past(in_run) |-> $stable(cause_reg);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed in run");
  property p_mode;
    @(posedge pclk) disable iff (!presetn) sample_now |=> background_mode == !$past(mode_pin_s);
  endproperty
  a_mode: assert property (p_mode) else $error("mode sampled wrong");
  property p_bit_time;
    @(posedge pclk) disable iff (!presetn) bdc_bit_tick |=> !bdc_bit_tick [*8] ##1 !bdc_bit_tick [*7] ##1 bdc_bit_tick;
  endproperty
  a_bit_time: assert property (p_bit_time) else $error("bit time not 16 clocks");
  property p_reset_pins;
    @(posedge pclk) disable iff (!presetn) !in_run |=> (pdir_reg == 8'h00) && (ppull_reg == 8'h00);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not reset to inputs");
  property p_pull_off_out;
    @(posedge pclk) disable iff (!presetn) (pads.pull_on & pads.oe) == 8'h00;
  endproperty
  a_pull_off_out: assert property (p_pull_off_out) else $error("pull on an output");
  // the full sequence is too long for a delay range; the pending cause carries it
  property p_force;
    @(posedge pclk) disable iff (!presetn) force_req |=> reset_pin_oe && pend_reg.debug_force;
  endproperty
  a_force: assert property (p_force) else $error("force reset lost");
  property p_any_trig;
    @(posedge pclk) disable iff (!presetn) trig |=> reset_pin_oe && !sys_rst_n;
  endproperty
  a_any_trig: assert property (p_any_trig) else $error("reset request not taken");
  property p_cause_set;
    @(posedge pclk) disable iff (!presetn) in_run |-> cause_reg != 5'h00;
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("no reset cause recorded");
  // the host must own the mode pin through the rising edge of reset
  property p_mode_free;
    @(posedge pclk) disable iff (!presetn) !in_run |-> !background_mode_select_pin_oe;
  endproperty
  a_mode_free: assert property (p_mode_free) else $error("mode pin driven in reset");
  property p_ready_pulse;
    @(posedge pclk) disable iff (!presetn) pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
  property p_err_ready;
    @(posedge pclk) disable iff (!presetn) pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_clk_int;
    @(posedge pclk) disable iff (!presetn) !in_run |-> !clk_sel_ext;
  endproperty
  a_clk_int: assert property (p_clk_int) else $error("external clock in startup");
endmodule : rmpc_top
`default_nettype wire

// ### pkg/rmpc_defines.svh
// constants of the reset, mode-select and pin-control block
`ifndef RMPC_DEFINES_SVH
`define RMPC_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define RMPC_OFF_PDATA 12'h000
`define RMPC_OFF_PDIR 12'h004
`define RMPC_OFF_PPULL 12'h008
`define RMPC_OFF_PSLEW 12'h00c
`define RMPC_OFF_CAUSE 12'h010
`define RMPC_OFF_CTRL 12'h014
`define RMPC_OFF_STAT 12'h018
// ****************************************
// control register fields
// ****************************************
`define RMPC_CTRL_RANGE 0
`define RMPC_CTRL_KBI_RISE 1
`define RMPC_CTRL_IRQ_RISE 2
`define RMPC_CTRL_FORCE 3
`define RMPC_CTRL_CLK_EXT 4
`define RMPC_CTRL_IRQ_PULL 5
`define RMPC_CTRL_W 6
// ****************************************
// port geometry and reset values
// ****************************************
`define RMPC_PORT_W 8
`define RMPC_KBI_LO 4
`define RMPC_PORT_RST 8'h00
`define RMPC_CTRL_RST 6'h00
`define RMPC_RESET_VECTOR 16'hfffe
// ****************************************
// timing
// ****************************************
`define RMPC_CLK_NS 4.0
`define RMPC_T_DRIVE_US 4.25
`define RMPC_T_SAMPLE_US 4.75
`define RMPC_BDC_BIT_CYC 16
`define RMPC_CNT_W 11
`endif

// ### pkg/rmpc_pkg.sv
// types of the reset, mode-select and pin-control block
package rmpc_pkg;
  // reset sequencer states
  typedef enum logic [1:0] {
    ST_DRIVE,
    ST_WAIT,
    ST_RUN
  } rmpc_state_t;
  // reset cause record, one bit per source
  typedef struct packed {
    logic debug_force;
    logic illegal_op;
    logic internal;
    logic external;
    logic power_on;
  } rmpc_cause_t;
  // pad controls of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_on;
    logic [7:0] pull_down;
    logic [7:0] slow;
  } rmpc_pads_t;
  // peripheral claim on the port pins
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] out;
  } rmpc_periph_t;
endpackage : rmpc_pkg

// ### verif/rmpc_far_side.sv
// far-side model: reset switch, reset pullup and debug host on the mode pin
`timescale 1ns/1ps
`default_nettype none
module rmpc_far_side (
  input wire logic reset_pin_oe,  // device pulls reset pin
  input wire logic reset_pin_out, // device drive value
  input wire logic mode_pin_oe,   // device drives mode pin
  input wire logic mode_pin_out,  // device drive value
  input wire logic switch_closed, // manual reset switch to ground
  input wire logic host_hold_low, // debug host pulls mode pin low
  output logic reset_level,       // resolved reset pin
  output logic mode_level         // resolved mode pin
);
  // ****************************************
  // wired pins with on-chip pullups
  // ****************************************
  // released pins rise to the pullup level, never keep the last driven value
  assign reset_level = (reset_pin_oe ? reset_pin_out : 1'b1) & ~switch_closed;
  // host low wins over pullup and device speedup; held through the reset edge
  assign mode_level = host_hold_low ? 1'b0 : (mode_pin_oe ? mode_pin_out : 1'b1);
endmodule : rmpc_far_side
`default_nettype wire

// ### verif/test_reset_mode_pin_control.sv
// self-checking bench of the reset, mode-select and pin-control block
`timescale 1ns/1ps
`default_nettype none
`include "rmpc_defines.svh"
module test_reset_mode_pin_control;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, int_req, ill_req, bdc_low, bdc_up, irq_in;
  logic rst_out, rst_oe, rst_lvl, sys_rst_n, bg_mode, mode_out, mode_oe, mode_lvl, tick, sw, host_low;
  logic irq_pon, irq_pdn, range_hi, clk_ext;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] vec;
  logic [7:0] pin_in;
  rmpc_pkg::rmpc_periph_t periph;
  rmpc_pkg::rmpc_pads_t pads;
  int mismatches, checks;
  // free-running 250 mhz bus clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  rmpc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .reset_pin_in(rst_lvl),
    .reset_pin_out(rst_out), .reset_pin_oe(rst_oe), .internal_reset_req(int_req), .illegal_op_req(ill_req),
    .sys_rst_n(sys_rst_n), .background_mode(bg_mode), .reset_vector_addr(vec),
    .background_mode_select_pin_in(mode_lvl), .background_mode_select_pin_out(mode_out),
    .background_mode_select_pin_oe(mode_oe), .bdc_drive_low(bdc_low), .bdc_speedup(bdc_up), .bdc_bit_tick(tick),
    .port_pin_in(pin_in), .periph(periph), .pads(pads), .irq_pin_in(irq_in), .irq_pull_on(irq_pon),
    .irq_pull_down(irq_pdn), .osc_range_high(range_hi), .clk_sel_ext(clk_ext));
  rmpc_far_side far (.reset_pin_oe(rst_oe), .reset_pin_out(rst_out), .mode_pin_oe(mode_oe),
    .mode_pin_out(mode_out), .switch_closed(sw), .host_hold_low(host_low), .reset_level(rst_lvl),
    .mode_level(mode_lvl));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop
  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      mismatches++;
      report_and_stop();
    end
  endtask : apb
  // bounded wait until the chip has stayed out of reset for 8 cycles
  task automatic wait_run;
    int n, hi;
    n = 0;
    hi = 0;
    while (hi < 8) begin
      @(posedge pclk);
      hi = (sys_rst_n === 1'b1) ? hi + 1 : 0;
      n++;
      if (n > 20000) begin
        mismatches++;
        report_and_stop();
      end
    end
  endtask : wait_run
  // trigger a reset from one source, time pin drive and chip reset, read cause
  task automatic reset_from(input int src, input logic [31:0] cause);
    int n_oe, n_rst;
    n_oe = 0;
    n_rst = 0;
    if (src == 2) begin
      apb(1'b1, `RMPC_OFF_CTRL, 32'h0000_0008);
    end else begin
      @(posedge pclk);
      int_req <= (src == 0);
      ill_req <= (src == 1);
      @(posedge pclk);
      int_req <= 1'b0;
      ill_req <= 1'b0;
    end
    repeat (2400) begin
      @(negedge pclk);
      n_oe += (rst_oe === 1'b1);
      n_rst += (sys_rst_n === 1'b0);
    end
    chk("pin drive cycles", 32'(n_oe), 32'd1063);
    chk("reset cycles", 32'(n_rst), 32'd2251);
    apb(1'b0, `RMPC_OFF_CAUSE, 32'h0);
    chk("cause", rd, cause);
    wait_run();
  endtask : reset_from
  // ****************************************
  // scenarios
  // ****************************************
  // cause survives time and a write attempt to the read-only register
  task automatic t_causes;
    reset_from(0, 32'h04);
    reset_from(1, 32'h08);
    reset_from(2, 32'h10);
    repeat (50) @(posedge pclk);
    apb(1'b1, `RMPC_OFF_CAUSE, 32'h0000_001f);
    apb(1'b0, `RMPC_OFF_CAUSE, 32'h0);
    chk("cause held", rd, 32'h10);
  endtask : t_causes
  // internal request, but the switch keeps the pin low past the sample point
  task automatic t_external;
    int n;
    @(posedge pclk);
    int_req <= 1'b1;
    sw <= 1'b1;
    @(posedge pclk);
    int_req <= 1'b0;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sys_rst_n !== 1'b1 && n < 3000);
    sw <= 1'b0;
    if (n >= 3000) begin
      mismatches++;
      report_and_stop();
    end
    // the still-low pin starts one more sequence, read while it runs
    apb(1'b0, `RMPC_OFF_CAUSE, 32'h0);
    chk("external cause", rd, 32'h02);
    wait_run();
    apb(1'b0, `RMPC_OFF_CAUSE, 32'h0);
    chk("pin reset cause", rd, 32'h02);
  endtask : t_external
  // host holds mode pin low through the reset edge, then leaves it free
  task automatic t_mode;
    host_low <= 1'b1;
    reset_from(0, 32'h04);
    host_low <= 1'b0;
    chk("background", {31'h0, bg_mode}, 32'h1);
    apb(1'b0, `RMPC_OFF_STAT, 32'h0);
    chk("status bg", rd, 32'h3);
    reset_from(0, 32'h04);
    chk("run mode", {31'h0, bg_mode}, 32'h0);
    chk("vector", {16'h0, vec}, 32'h0000_fffe);
  endtask : t_mode
  // port direction, read path, ownership, pulls, slew and clock controls
  task automatic t_pins;
    periph <= '{own: 8'hf0, oe: 8'h30, out: 8'h10};
    pin_in <= 8'h5a;
    apb(1'b1, `RMPC_OFF_PDIR, 32'h0f);
    apb(1'b1, `RMPC_OFF_PDATA, 32'ha5);
    apb(1'b1, `RMPC_OFF_PPULL, 32'hff);
    apb(1'b1, `RMPC_OFF_PSLEW, 32'h3c);
    apb(1'b1, `RMPC_OFF_CTRL, 32'h37);
    repeat (4) @(posedge pclk);
    apb(1'b0, `RMPC_OFF_PDATA, 32'h0);
    chk("read path", rd, 32'h55);
    chk("pad oe", {24'h0, pads.oe}, 32'h3f);
    chk("pad out", {24'h0, pads.out}, 32'h15);
    chk("pull on", {24'h0, pads.pull_on}, 32'hc0);
    chk("kbi pulldown", {24'h0, pads.pull_down & pads.pull_on}, 32'hc0);
    chk("slew", {24'h0, pads.slow}, 32'h3c);
    chk("irq pull", {30'h0, irq_pon, irq_pdn}, 32'h3);
    chk("range clk", {30'h0, range_hi, clk_ext}, 32'h3);
    apb(1'b0, `RMPC_OFF_CTRL, 32'h0);
    chk("ctrl read", rd, 32'h37);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", {rd[30:0], err}, 32'h1);
    // peripherals give the pins back before the reset scenarios
    periph <= '0;
  endtask : t_pins
  // background pin drive and bit timing
  task automatic t_bdc;
    int n;
    bdc_low <= 1'b1;
    @(negedge pclk);
    chk("bdc low", {30'h0, mode_oe, mode_out}, 32'h2);
    @(posedge pclk);
    bdc_low <= 1'b0;
    bdc_up <= 1'b1;
    @(negedge pclk);
    chk("bdc speedup", {30'h0, mode_oe, mode_out}, 32'h3);
    @(posedge pclk);
    bdc_up <= 1'b0;
    n = 0;
    while (tick !== 1'b1 && n < 40) begin
      @(negedge pclk);
      n++;
    end
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (tick !== 1'b1 && n < 40);
    chk("bit time", 32'(n), 32'd16);
  endtask : t_bdc
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    mismatches = 0;
    checks = 0;
    {presetn, psel, penable, pwrite, int_req, ill_req, bdc_low, bdc_up, irq_in, sw, host_low} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pin_in = 8'h00;
    periph = '0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    wait_run();
    apb(1'b0, `RMPC_OFF_CAUSE, 32'h0);
    chk("power-on cause", rd, 32'h01);
    chk("reset pads", {8'h0, pads.oe, pads.pull_on, 7'h0, mode_oe}, 32'h0);
    chk("internal clock", {31'h0, clk_ext}, 32'h0);
    t_pins();
    t_bdc();
    t_causes();
    chk("pads cleared", {16'h0, pads.oe, pads.pull_on}, 32'h0);
    t_mode();
    t_external();
    report_and_stop();
  end
endmodule : test_reset_mode_pin_control
`default_nettype wire
